// ===== tb/pin_en_chk.sv
// Port assertions for the pin enable register block.
// Assumes one clock and the block's async reset.
`timescale 1ns/1ps
module pin_en_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] portd_drive_en,
    input wire logic [4:0] porte_drive_en,
    input wire logic [7:0] porta_sense_en,
    input wire logic [7:0] porta_in_level
);
default clocking @(posedge mclk); endclocking
default disable iff (sys_rst);
sequence s_reset_held;
    sys_rst ##1 sys_rst;
endsequence
sequence s_portd_read;
    reg_rd && reg_addr == 16'h30B3;
endsequence
sequence s_porta_read;
    reg_rd && reg_addr == 16'h30B8;
endsequence
a_portd_load: assert property (reg_wr && reg_addr == 16'h30B3 |=> portd_drive_en == $past(reg_wdata))
    else $error("port d load");
a_portd_hold: assert property (!(reg_wr && reg_addr == 16'h30B3) |=> $stable(portd_drive_en))
    else $error("port d hold");
a_porte_load: assert property (reg_wr && reg_addr == 16'h30B4 |=> {3'h0, porte_drive_en} == ($past(reg_wdata) & 8'h1F))
    else $error("port e load");
a_porte_rsvd: assert property (reg_rd && reg_addr == 16'h30B4 |=> reg_rdata == {3'h0, $past(porte_drive_en)})
    else $error("port e read");
a_sense_load: assert property (reg_wr && reg_addr == 16'h30B8 |=> porta_sense_en == ($past(reg_wdata) & 8'hEF))
    else $error("port a load");
a_input_gate: assert property ((porta_in_level & ~$past(porta_sense_en)) == 8'h00)
    else $error("input gate");
a_sense_rsvd: assert property (porta_sense_en[4] == 1'b0)
    else $error("port a bit 4");
a_portd_read: assert property (s_portd_read |=> reg_rdata == $past(portd_drive_en))
    else $error("port d read");
a_porta_read: assert property (s_porta_read |=> reg_rdata == $past(porta_sense_en))
    else $error("port a read");
a_reset_zero: assert property (disable iff (1'b0) s_reset_held |->
    portd_drive_en == 8'h00 && porte_drive_en == 5'h00 && porta_sense_en == 8'h00 && reg_rdata == 8'h00)
    else $error("reset value");
endmodule : pin_en_chk
bind port_pin_direction_enables pin_en_chk u_chk (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .portd_drive_en, .porte_drive_en, .porta_sense_en, .porta_in_level);

// ===== tb/tb_port_pin_direction_enables.sv
// Self-checking bench for the pin enable register block.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module tb_port_pin_direction_enables;
import pin_enable_pkg::*;
logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
reg_addr_t reg_addr = '0;
reg_byte_t reg_wdata = '0, porta_pad_level = '0, reg_rdata, portd_drive_en, porta_sense_en, porta_in_level;
logic [4:0] porte_drive_en;
int fail_count = 0, compares = 0, k;
reg_addr_t adr[4] = '{16'h30B3, 16'h30B4, 16'h30B8, 16'h30B5};
reg_byte_t msk[4] = '{8'hFF, 8'h1F, 8'hEF, 8'h00}, m[4] = '{default: 8'h00};
always #5 mclk = ~mclk;
port_pin_direction_enables i_dut (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .portd_drive_en, .porte_drive_en, .porta_pad_level, .porta_sense_en, .porta_in_level);
task automatic chk(input reg_byte_t g, input reg_byte_t x);
    compares++;
    if (g !== x) begin fail_count++; $display("wrong value at %0t: %h expected %h", $time, g, x); end
endtask : chk
task automatic wr(input int i, input reg_byte_t v);
    @(posedge mclk); reg_wr <= 1; reg_addr <= adr[i]; reg_wdata <= v; m[i] = v & msk[i];
    @(posedge mclk); reg_wr <= 0;
endtask : wr
task automatic rd(input int i);
    @(posedge mclk); reg_rd <= 1; reg_addr <= adr[i];
    @(posedge mclk); reg_rd <= 0;
    #1 chk(reg_rdata, m[i]);
    chk(portd_drive_en, m[0]);
    chk({3'h0, porte_drive_en}, m[1]);
    chk(porta_sense_en, m[2]);
    @(posedge mclk); #1 chk(reg_rdata, 8'h00);
endtask : rd
task give_verdict;
    $display("mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask : give_verdict
// A hundred microseconds is several times the run, so only a hang reaches it.
initial begin #100us; fail_count++; give_verdict; end
initial begin
    void'($urandom(32'h86b9a98d));
    repeat (10) @(posedge mclk);
    sys_rst <= 0;
    for (int i = 0; i < 4; i++) rd(i);
    wr(1, 8'hFF); wr(2, 8'hFF); rd(1); rd(2);
    repeat (200) begin
        k = $urandom_range(3);
        wr(k, 8'($urandom)); rd(k);
        @(posedge mclk); porta_pad_level <= 8'($urandom);
        repeat (3) @(posedge mclk);
        #1 chk(porta_in_level, porta_pad_level & m[2]);
    end
    // A reset in mid-run must bring every enable back to zero.
    @(posedge mclk); sys_rst <= 1;
    repeat (3) @(posedge mclk);
    sys_rst <= 0; m = '{default: 8'h00};
    for (int i = 0; i < 4; i++) rd(i);
    chk(porta_in_level, 8'h00);
    // Write then read with no idle cycle between the strobes.
    @(posedge mclk); reg_wr <= 1; reg_addr <= adr[0]; reg_wdata <= 8'h5A; m[0] = 8'h5A;
    @(posedge mclk); reg_wr <= 0; reg_rd <= 1;
    @(posedge mclk); reg_rd <= 0;
    #1 chk(reg_rdata, m[0]);
    give_verdict;
end
endmodule : tb_port_pin_direction_enables

// ===== verilog/pin_enable_map.svh
// Register offsets, field masks and reset values of the pin enable registers.
// Assumes a byte-wide register port addressed by the offsets below.
`ifndef PIN_ENABLE_MAP_SVH
`define PIN_ENABLE_MAP_SVH
`define PORTD_OE_ADDR 16'h30B3
`define PORTE_OE_ADDR 16'h30B4
`define PORTA_IE_ADDR 16'h30B8
`define PORTD_OE_MASK 8'hFF
`define PORTE_OE_MASK 8'h1F
`define PORTA_IE_MASK 8'hEF
`define PORTD_OE_RESET 8'h00
`define PORTE_OE_RESET 8'h00
`define PORTA_IE_RESET 8'h00
`endif

// ===== verilog/pin_enable_pkg.sv
// Types shared by the pin enable register block.
// Assumes nothing beyond a SystemVerilog compiler.
package pin_enable_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [15:0] reg_addr_t;
endpackage : pin_enable_pkg

// ===== verilog/port_pin_direction_enables.sv
// Port D and E output enables and port A input enables with their register port.
// Assumes a same-clock register master and pads that take per-pin enables and levels.
// The enables leave on flop outputs; the pad drivers and input buffers sit outside.
//
// Design decision made here: the strobed register port.

`timescale 1ns/1ps
`include "pin_enable_map.svh"
module port_pin_direction_enables
    import pin_enable_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] portd_drive_en,
    output logic [4:0] porte_drive_en,
    input wire logic [7:0] porta_pad_level,
    output logic [7:0] porta_sense_en,
    output logic [7:0] porta_in_level
);

    // Address decode for the write strobes; the read path decodes reg_addr in its own case on the same offsets.
    logic portd_sel;
    logic porte_sel;
    logic porta_sel;
    logic portd_wr;
    logic porte_wr;
    logic porta_wr;

    // Stored enables and their next values; reserved bits are stored as zero.
    reg_byte_t portd_oe_r;
    reg_byte_t porte_oe_r;
    reg_byte_t porta_ie_r;
    reg_byte_t portd_oe_nxt;
    reg_byte_t porte_oe_nxt;
    reg_byte_t porta_ie_nxt;

    reg_byte_t rdata_nxt;
    reg_byte_t porta_in_nxt;
    wire [7:0] porta_gated;

    assign portd_sel = (reg_addr == `PORTD_OE_ADDR);
    assign porte_sel = (reg_addr == `PORTE_OE_ADDR);
    assign porta_sel = (reg_addr == `PORTA_IE_ADDR);

    // The master never raises both strobes, so a write needs only its own strobe and select.
    assign portd_wr = reg_wr && portd_sel;
    assign porte_wr = reg_wr && porte_sel;
    assign porta_wr = reg_wr && porta_sel;

    // Port D has all eight bits implemented.
    always_comb
    begin
        portd_oe_nxt = portd_oe_r;
        if (portd_wr)
        begin
            portd_oe_nxt = reg_wdata & `PORTD_OE_MASK;
        end
    end

    // Reserved bits are masked on the way in, so the stored copy already reads as zero.
    always_comb
    begin
        porte_oe_nxt = porte_oe_r;
        if (porte_wr)
        begin
            porte_oe_nxt = reg_wdata & `PORTE_OE_MASK;
        end
    end

    // Port A bit 4 has no input path behind it, so it is masked like the port E spares.
    always_comb
    begin
        porta_ie_nxt = porta_ie_r;
        if (porta_wr)
        begin
            porta_ie_nxt = reg_wdata & `PORTA_IE_MASK;
        end
    end

    // Every register loads its next value on every edge; the logic above decides whether it changes.
    // Port D output enables.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            portd_oe_r <= `PORTD_OE_RESET;
        end
        else
        begin
            portd_oe_r <= portd_oe_nxt;
        end
    end

    // Port E output enables.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            porte_oe_r <= `PORTE_OE_RESET;
        end
        else
        begin
            porte_oe_r <= porte_oe_nxt;
        end
    end

    // Port A input enables.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            porta_ie_r <= `PORTA_IE_RESET;
        end
        else
        begin
            porta_ie_r <= porta_ie_nxt;
        end
    end

    // Unmapped addresses and idle cycles read as zero, so stale data never reaches the bus.
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `PORTD_OE_ADDR:
                begin
                    rdata_nxt = portd_oe_r;
                end
                `PORTE_OE_ADDR:
                begin
                    rdata_nxt = porte_oe_r & `PORTE_OE_MASK;
                end
                `PORTA_IE_ADDR:
                begin
                    rdata_nxt = porta_ie_r & `PORTA_IE_MASK;
                end
                default:
                begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // Read data is held only in the cycle after the strobe; otherwise zero.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Pad levels are asynchronous, so each pin passes two flops before any gating.
    // Each pin has its own chain, so a slow pad cannot disturb its neighbours.
    genvar pin;
    generate
        for (pin = 0; pin < 8; pin = pin + 1)
        begin : g_porta_pin
            logic sync1_r;
            logic sync2_r;

            always_ff @(posedge mclk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    sync1_r <= 1'b0;
                    sync2_r <= 1'b0;
                end
                else
                begin
                    sync1_r <= porta_pad_level[pin];
                    sync2_r <= sync1_r;
                end
            end

            // A disabled pin contributes zero, never its pad level.
            assign porta_gated[pin] = sync2_r & porta_ie_r[pin];
        end
    endgenerate

    // The gated level is registered so that every pin-side output comes from a flop.
    always_comb
    begin
        porta_in_nxt = porta_gated;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            porta_in_level <= 8'h00;
        end
        else
        begin
            porta_in_level <= porta_in_nxt;
        end
    end

    // A write reaches the pins one edge after its strobe; there is no shadow copy.
    assign portd_drive_en = portd_oe_r;
    assign porte_drive_en = porte_oe_r[4:0];
    assign porta_sense_en = porta_ie_r;
endmodule : port_pin_direction_enables
